/* File: verilog/idc_defs.vh */
// Constants for the interrupt daisy chain controller
`ifndef IDC_DEFS_VH
`define IDC_DEFS_VH

// Processor address bus width
`define IDC_ADDR_W        12
// Processor data bus width
`define IDC_DATA_W        8
// Default number of interrupt sources
`define IDC_NUM_SRC       8

// Fixed interrupt entry address
`define IDC_ENTRY_ADDR    12'h002
// Acknowledge write address
`define IDC_ACK_ADDR      12'hff0
// Data bit that carries the acknowledge, and its active value
`define IDC_ACK_BIT       0
`define IDC_ACK_BIT_VAL   1'b0
// Input port address that returns the grant vector
`define IDC_GRANT_PORT    12'hff1
// Shared service memory region, one bank per source
`define IDC_SHARED_LO     12'h800
`define IDC_SHARED_HI     12'hbff
// Upper end of the unshared region
`define IDC_COMMON_HI     12'h7ff

// Acknowledge schemes
`define IDC_MODE_WRITE    1'b0
`define IDC_MODE_ADDR     1'b1

`endif

/* File: verilog/idc_chain.v */
// Combinational daisy chain of gating stages
`timescale 1ns/1ns
`include "idc_defs.vh"

module idc_chain #(
  parameter NUM_SRC = `IDC_NUM_SRC
) (
  // Master acknowledge, low active
  input  wire               ack_n,
  // Per-source requests, low active
  input  wire [NUM_SRC-1:0] req_n,
  // Per-source grants, high active
  output reg  [NUM_SRC-1:0] grant
);

  reg [NUM_SRC:0] en_n;
  integer         i;

  // Ripple the low enable down the chain, first low request takes it
  always @* begin
    en_n    = {(NUM_SRC+1){1'b1}};
    grant   = {NUM_SRC{1'b0}};
    en_n[0] = ack_n;                       // see [R03]
    for (i = 0; i < NUM_SRC; i = i + 1) begin
      grant[i]  = ~en_n[i] & ~req_n[i];    // see [R04] see [R06]
      en_n[i+1] = en_n[i] | grant[i];      // see [R05]
    end
  end

endmodule

/* File: verilog/idc_top.v */
// Interrupt arbitration and acknowledge controller, processor side
//
// Overview of operation
// [R01] Each source has its own low-active request
// [R02] All requests ANDed into one master request
// [R03] Master acknowledge is active low toward chain
// [R04] First stage grants source zero, blocks later
// [R05] High request passes enable to next stage
// [R06] Grants are high, only for selected source
// [R07] Service one at a time, others wait
// [R08] Acknowledged processor branches to entry 002
// [R09] Write FF0 with bit zero low acknowledges
// [R10] Alternative: decode entry address as acknowledge
// [R11] Grants readable on an input port
// [R12] Shared service banks qualified by grant
// [R13] Single source needs no extra logic
// [R14] Serviced source releases request, ending grant
`timescale 1ns/1ns
`include "idc_defs.vh"

module idc_top #(
  parameter NUM_SRC = `IDC_NUM_SRC,
  parameter ADDR_W  = `IDC_ADDR_W,
  parameter DATA_W  = `IDC_DATA_W
) (
  // Clock and reset
  input  wire               REF_CLK,
  input  wire               RST,
  // Source side
  input  wire [NUM_SRC-1:0] SOURCE_REQUEST_N,
  output reg  [NUM_SRC-1:0] SOURCE_GRANT,
  // Processor request and acknowledge
  output reg                MASTER_REQUEST_N,
  output reg                MASTER_GRANT_N,
  // Processor bus view
  input  wire               ACK_MODE,
  input  wire [ADDR_W-1:0]  ADDR,
  input  wire               ADDR_STB,
  input  wire               WR_STB,
  input  wire               RD_STB,
  input  wire [DATA_W-1:0]  DATA_IN,
  // Grant input port
  output reg  [DATA_W-1:0]  GRANT_PORT_DATA,
  output reg                GRANT_PORT_SEL,
  // Shared service bank selects
  output reg  [NUM_SRC-1:0] BANK_SEL
);

  // Address equality against a constant
  function addr_is;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ref_a;
    begin
      addr_is = (a == ref_a);
    end
  endfunction

  // Address inside an inclusive range
  function addr_in;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] lo;
    input [ADDR_W-1:0] hi;
    begin
      addr_in = (a >= lo) && (a <= hi);
    end
  endfunction

  // Controller states
  localparam ST_IDLE  = 2'd0;
  localparam ST_GRANT = 2'd1;
  localparam ST_DONE  = 2'd2;

  reg  [1:0]         state_r;
  reg  [1:0]         state_nxt;
  reg  [NUM_SRC-1:0] grant_r;
  reg  [NUM_SRC-1:0] grant_nxt;
  reg                ack_n_nxt;
  wire               any_req;
  wire               sw_ack;
  wire               hw_ack;
  wire               ack_trig;
  wire               ack_n_now;
  wire [NUM_SRC-1:0] chain_grant;
  wire               released;
  wire [DATA_W-1:0]  port_word;

  // Any source pulling its request low
  assign any_req = ~(&SOURCE_REQUEST_N);                 // see [R01] see [R02]

  // Software scheme: write to the acknowledge address with bit zero low
  assign sw_ack = (ACK_MODE == `IDC_MODE_WRITE) && WR_STB &&
                  addr_is(ADDR, `IDC_ACK_ADDR) &&
                  (DATA_IN[`IDC_ACK_BIT] == `IDC_ACK_BIT_VAL);  // see [R09]

  // Address scheme: the branch to the entry address is the acknowledge
  assign hw_ack = (ACK_MODE == `IDC_MODE_ADDR) && ADDR_STB &&
                  addr_is(ADDR, `IDC_ENTRY_ADDR);        // see [R08] see [R10]

  // Acknowledge only taken when idle, so one source is served at a time
  assign ack_trig  = (sw_ack | hw_ack) && (state_r == ST_IDLE);  // see [R07]
  assign ack_n_now = ~ack_trig;                          // see [R03]

  // Chain sampled at the acknowledge moment
  idc_chain #(
    .NUM_SRC (NUM_SRC)
  ) u_chain (
    .ack_n   (ack_n_now),
    .req_n   (SOURCE_REQUEST_N),
    .grant   (chain_grant)
  );

  // Granted source has released its request
  assign released = ~(|(grant_r & ~SOURCE_REQUEST_N));  // see [R14]

  // Grant vector placed on the low bits of the input port
  generate
    if (DATA_W > NUM_SRC) begin : g_pad
      assign port_word = {{(DATA_W-NUM_SRC){1'b0}}, grant_r};
    end else begin : g_cut
      assign port_word = grant_r[DATA_W-1:0];
    end
  endgenerate

  // Next state of the acknowledge sequence
  always @* begin
    state_nxt = state_r;
    grant_nxt = grant_r;
    ack_n_nxt = 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (ack_trig) begin
          grant_nxt = chain_grant;                       // see [R06]
          state_nxt = ST_GRANT;
          ack_n_nxt = 1'b0;
        end
      end
      ST_GRANT: begin
        // Hold grant and acknowledge until the source lets go
        if (released) begin                              // see [R14]
          grant_nxt = {NUM_SRC{1'b0}};
          state_nxt = ST_DONE;
        end else begin
          ack_n_nxt = 1'b0;
        end
      end
      ST_DONE: begin
        // One idle cycle so the master request settles
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        grant_nxt = {NUM_SRC{1'b0}};
      end
    endcase
  end

  // State and grant registers
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
      grant_r <= {NUM_SRC{1'b0}};
    end else begin
      state_r <= state_nxt;
      grant_r <= grant_nxt;
    end
  end

  // Registered outputs toward processor and sources
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MASTER_REQUEST_N <= 1'b1;
      MASTER_GRANT_N   <= 1'b1;
      SOURCE_GRANT     <= {NUM_SRC{1'b0}};
    end else begin
      MASTER_REQUEST_N <= ~any_req;                      // see [R02] see [R13]
      MASTER_GRANT_N   <= ack_n_nxt;                     // see [R03]
      SOURCE_GRANT     <= grant_nxt;                     // see [R06]
    end
  end

  // Grant input port, selected on a read of its address
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      GRANT_PORT_DATA <= {DATA_W{1'b0}};
      GRANT_PORT_SEL  <= 1'b0;
    end else begin
      GRANT_PORT_DATA <= port_word;                      // see [R11]
      GRANT_PORT_SEL  <= RD_STB && addr_is(ADDR, `IDC_GRANT_PORT);
    end
  end

  // Shared bank select qualified by the held grant
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BANK_SEL <= {NUM_SRC{1'b0}};
    end else if (ADDR_STB && addr_in(ADDR, `IDC_SHARED_LO, `IDC_SHARED_HI)) begin
      BANK_SEL <= grant_r;                               // see [R12]
    end else begin
      BANK_SEL <= {NUM_SRC{1'b0}};
    end
  end

endmodule

/* File: verification/idc_checker.sv */
// Port assertions for the interrupt chain controller
`timescale 1ns/1ns
module idc_checker #(
  parameter NUM_SRC = 8,
  parameter ADDR_W  = 12,
  parameter DATA_W  = 8
) (
  // Clock, reset, chain
  input wire               REF_CLK,
  input wire               RST,
  input wire [NUM_SRC-1:0] SOURCE_REQUEST_N,
  input wire [NUM_SRC-1:0] SOURCE_GRANT,
  input wire               MASTER_REQUEST_N,
  input wire               MASTER_GRANT_N,
  // Processor bus view
  input wire               ACK_MODE,
  input wire [ADDR_W-1:0]  ADDR,
  input wire               ADDR_STB,
  input wire               WR_STB,
  input wire [DATA_W-1:0]  DATA_IN,
  input wire [NUM_SRC-1:0] BANK_SEL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_req_and: assert property (MASTER_REQUEST_N == &$past(SOURCE_REQUEST_N))
    else $error("bad master request");
  a_grant_one: assert property ($onehot0(SOURCE_GRANT))
    else $error("several grants");
  a_chain_prio: assert property ($fell(MASTER_GRANT_N) |->
    SOURCE_GRANT == (~$past(SOURCE_REQUEST_N) & ($past(SOURCE_REQUEST_N) + 1'b1))) else $error("wrong grant");
  a_write_ack: assert property (!ACK_MODE && WR_STB && ADDR == 12'hff0 && !DATA_IN[0]
    && MASTER_GRANT_N && $past(MASTER_GRANT_N) |=> !MASTER_GRANT_N) else $error("write ack lost");
  a_addr_ack: assert property (ACK_MODE && ADDR_STB && ADDR == 12'h002
    && MASTER_GRANT_N && $past(MASTER_GRANT_N) |=> !MASTER_GRANT_N) else $error("entry ack lost");
  a_grant_hold: assert property (!MASTER_GRANT_N && |(SOURCE_GRANT & ~SOURCE_REQUEST_N) |=>
    $stable(SOURCE_GRANT) && !MASTER_GRANT_N) else $error("grant moved");
  a_grant_release: assert property (|(SOURCE_GRANT & SOURCE_REQUEST_N) |=>
    MASTER_GRANT_N && SOURCE_GRANT == 0) else $error("grant kept");
  a_bank_sel: assert property (ADDR_STB && ADDR >= 12'h800 && ADDR <= 12'hbff |=>
    BANK_SEL == $past(SOURCE_GRANT)) else $error("bad bank select");
  cover property ($fell(MASTER_GRANT_N));
  cover property (|(SOURCE_GRANT & SOURCE_REQUEST_N));
  cover property (|BANK_SEL);
endmodule
bind idc_top idc_checker #(.NUM_SRC(NUM_SRC), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) idc_checker_inst (.*);

/* File: verification/idc_source_model.sv */
// Interrupting sources that hold requests until serviced
`timescale 1ns/1ns
module idc_source_model (
  // Clock and commands
  input  wire       clk,
  input  wire [7:0] raise,
  input  wire       done,
  // Request and grant lines
  input  wire [7:0] grant,
  output reg  [7:0] req_n_r
);
  initial req_n_r = 8'hff;
  // Low request per source; waits until its grant is serviced
  always @(posedge clk) begin
    req_n_r <= (req_n_r & ~raise) | (done ? grant : 8'h00);
  end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the interrupt chain controller
`timescale 1ns/1ns
module testbench;
  reg         clk = 1'b0, rst = 1'b1, mode = 1'b0, astb = 1'b0, wstb = 1'b0, rstb = 1'b0, done = 1'b0;
  reg  [11:0] addr = 12'h000;
  reg  [7:0]  din = 8'h00, raise = 8'h00;
  reg  [16:0] rows [0:4];
  wire [7:0]  req_n, grant, pdata, bank;
  wire        mreq_n, mgnt_n, psel;
  integer     fails = 0, checks = 0, i, n;
  always #5 clk = ~clk;
  idc_top idc_top_inst (.REF_CLK(clk), .RST(rst), .SOURCE_REQUEST_N(req_n), .SOURCE_GRANT(grant),
    .MASTER_REQUEST_N(mreq_n), .MASTER_GRANT_N(mgnt_n), .ACK_MODE(mode), .ADDR(addr), .ADDR_STB(astb),
    .WR_STB(wstb), .RD_STB(rstb), .DATA_IN(din), .GRANT_PORT_DATA(pdata), .GRANT_PORT_SEL(psel), .BANK_SEL(bank));
  idc_source_model idc_source_model_inst (.clk(clk), .raise(raise), .done(done), .grant(grant), .req_n_r(req_n));
  // Compare and count
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Acknowledge by entry address or by write, one strobe cycle
  task ack(input m, input [7:0] d);
    begin
      @(negedge clk);
      mode = m;
      addr = m ? 12'h002 : 12'hff0;
      astb = m;
      wstb = !m;
      din = d;
      @(negedge clk);
      astb = 1'b0;
      wstb = 1'b0;
    end
  endtask
  // One read or address strobe
  task probe(input r, input [11:0] a);
    begin
      @(negedge clk);
      rstb = r;
      astb = !r;
      addr = a;
      @(negedge clk);
      rstb = 1'b0;
      astb = 1'b0;
    end
  endtask
  // Raise sources, then let the master request settle
  task post(input [7:0] r);
    begin
      raise = r;
      @(negedge clk);
      raise = 8'h00;
      @(negedge clk);
    end
  endtask
  // Service the granted source, wait for release and settle
  task release_src;
    begin
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      n = 0;
      while (mgnt_n !== 1'b1 && n < 20) begin
        @(negedge clk);
        n = n + 1;
      end
      if (mgnt_n !== 1'b1) begin
        fails = fails + 1;
        summarize;
      end
      repeat (2) @(negedge clk);
    end
  endtask
  // Reset, table of grants, then awkward cases
  initial begin
    rows[0] = {8'ha4, 1'b0, 8'h04};
    rows[1] = {8'h00, 1'b1, 8'h20};
    rows[2] = {8'h00, 1'b0, 8'h80};
    rows[3] = {8'h01, 1'b1, 8'h01};
    rows[4] = {8'h00, 1'b0, 8'h00};
    repeat (6) @(negedge clk);
    check(grant, 8'h00);
    check({7'h00, mgnt_n}, 8'h01);
    rst = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      post(rows[i][16:9]);
      check({7'h00, mreq_n}, {7'h00, rows[i][7:0] == 8'h00});
      ack(rows[i][8], 8'h00);
      check(grant, rows[i][7:0]);
      check({7'h00, mgnt_n}, 8'h00);
      probe(1'b0, 12'h850);
      check(bank, rows[i][7:0]);
      check(pdata, rows[i][7:0]);
      release_src;
    end
    post(8'h02);
    ack(1'b0, 8'h01);
    check({7'h00, mgnt_n}, 8'h01);
    ack(1'b0, 8'hfe);
    check(grant, 8'h02);
    post(8'h01);
    ack(1'b1, 8'h00);
    check(grant, 8'h02);
    probe(1'b1, 12'hff1);
    check({7'h00, psel}, 8'h01);
    release_src;
    ack(1'b0, 8'h00);
    check(grant, 8'h01);
    release_src;
    summarize;
  end
endmodule
